// *** verilog/lcem_pkg.sv ***
// Overview of operation
// R1 - code 0x20 asserts each cycle address ring egress credits are empty; counters 0-3
// R2 - 0x20 mask: bit0 shared pool, bits1-3 and 4-6 per-network request/snoop/response
// R3 - code 0x21 asserts each cycle data ring egress credits are empty; counters 0-3
// R4 - 0x21 mask: bit0 shared pool, bits1-3 and 4-6 response/noncoherent/writeback per network
// R5 - code 0x29 pulses once per flow queue spawned prefetch toward memory target
// R6 - code 0x5b counts each use of a network zero credit
// R7 - request tries shared pool first, falls back to reserved credit only on failure
// R8 - shared pool spends one credit per flit buffer; reserved network spends one credit
// R9 - credit masks: bits0-2 request/snoop/response address ring, bits3-5 response/writeback/noncoherent data ring
// R10 - code 0x5d asserts each cycle network zero credits are empty for selected classes
// R11 - code 0x5c counts each network one credit use, taken only after shared pool failure
// R12 - code 0x5e asserts each cycle network one credits are empty for selected classes
// R13 - code 0x7e compares route-through and local writeback occupancy; mask bit7 requires both nonzero
// R14 - code 0x7d reports pending writebacks: local, route-through, both, waiting pull per network
// R15 - code 0x61 reports crosspoint prefetch stages selected by mask bits
// R16 - prefetch drops counted apart: grown too old, overwritten while queue full
// R17 - several mask bits set count when any selected condition holds
package lcem_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_SLOTS = 4;
  localparam int NUM_CLASSES = 6;
  localparam int CRED_W = 4;
  localparam int POOL_W = 6;
  localparam int OCC_W = 8;

  // register offsets
  localparam logic [7:0] OFF_SLOT_CTL0 = 8'h00;
  localparam logic [7:0] OFF_CREDIT_CFG = 8'h10;
  localparam logic [7:0] OFF_CREDIT_STAT = 8'h14;
  localparam logic [7:0] OFF_EMPTY_STAT = 8'h18;

  // slot control fields
  localparam int CTL_CODE_LSB = 0;
  localparam int CTL_MASK_LSB = 8;
  localparam int CTL_EN_BIT = 22;

  // credit config fields
  localparam int CFG_POOL_AD_LSB = 0;
  localparam int CFG_POOL_DATA_LSB = 8;
  localparam int CFG_RSV_LSB = 16;
  localparam logic [31:0] CREDIT_CFG_RST = 32'h0004_2020;

  // message classes: 0-2 address ring, 3-5 data ring
  localparam logic [2:0] CLS_REQ = 3'h0;
  localparam logic [2:0] CLS_SNP = 3'h1;
  localparam logic [2:0] CLS_RSP_AD = 3'h2;
  localparam logic [2:0] CLS_RSP_DATA = 3'h3;
  localparam logic [2:0] CLS_WB = 3'h4;
  localparam logic [2:0] CLS_NONCOH = 3'h5;
  localparam logic [2:0] CLS_FIRST_DATA = 3'h3;

  // event codes
  localparam logic [7:0] EV_AD_EMPTY = 8'h20;
  localparam logic [7:0] EV_DATA_EMPTY = 8'h21;
  localparam logic [7:0] EV_PF_SPAWN = 8'h29;
  localparam logic [7:0] EV_VN0_USED = 8'h5b;
  localparam logic [7:0] EV_VN1_USED = 8'h5c;
  localparam logic [7:0] EV_VN0_NONE = 8'h5d;
  localparam logic [7:0] EV_VN1_NONE = 8'h5e;
  localparam logic [7:0] EV_XPT_PF = 8'h61;
  localparam logic [7:0] EV_WB_PEND = 8'h7d;
  localparam logic [7:0] EV_WB_CMP = 8'h7e;

  localparam int CMP_NZ_BIT = 7;
endpackage : lcem_pkg

// *** verilog/lcem_event_sel.sv ***
`timescale 1ns/1ps
module lcem_event_sel (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // selection
  input  wire logic       en,
  input  wire logic [7:0] code,
  input  wire logic [7:0] umask,
  // condition vectors, one per code, two for code 0x7e
  input  wire logic [7:0] v_ad_empty,
  input  wire logic [7:0] v_data_empty,
  input  wire logic       v_pf_spawn,
  input  wire logic [7:0] v_vn0_used,
  input  wire logic [7:0] v_vn1_used,
  input  wire logic [7:0] v_vn0_none,
  input  wire logic [7:0] v_vn1_none,
  input  wire logic [7:0] v_xpt,
  input  wire logic [7:0] v_wb_pend,
  input  wire logic [7:0] v_cmp_any,
  input  wire logic [7:0] v_cmp_nz,
  // increment to the counter
  output logic            inc
);
  import lcem_pkg::*;

  logic hit;

  always_comb begin
    hit = 1'b0;
    // R17 any selected bit
    case (code)
      // R1 address ring empty
      EV_AD_EMPTY:   hit = |(umask & v_ad_empty);
      // R3 data ring empty
      EV_DATA_EMPTY: hit = |(umask & v_data_empty);
      // R5 no mask qualifier
      EV_PF_SPAWN:   hit = v_pf_spawn;
      // R6 zero used
      EV_VN0_USED:   hit = |(umask & v_vn0_used);
      // R11 one used
      EV_VN1_USED:   hit = |(umask & v_vn1_used);
      // R10 zero empty
      EV_VN0_NONE:   hit = |(umask & v_vn0_none);
      // R12 one empty
      EV_VN1_NONE:   hit = |(umask & v_vn1_none);
      // R15 prefetch stages
      EV_XPT_PF:     hit = |(umask & v_xpt);
      // R14 pending writebacks
      EV_WB_PEND:    hit = |(umask & v_wb_pend);
      // R13 bit7 picks nonzero qualifier
      EV_WB_CMP:     hit = umask[CMP_NZ_BIT] ? |(umask[6:0] & v_cmp_nz[6:0])
                                             : |(umask[6:0] & v_cmp_any[6:0]);
      default:       hit = 1'b0;
    endcase
  end

  // at most one per cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      inc <= 1'b0;
    end else begin
      inc <= en & hit;
    end
  end
endmodule : lcem_event_sel

// *** verilog/lcem_monitor.sv ***
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module lcem_monitor (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  // register port
  input  wire logic [lcem_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [lcem_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [lcem_pkg::DATA_W-1:0]   reg_rdata,
  // egress transfer request
  input  wire logic                          tx_valid,
  input  wire logic                          tx_vn,
  input  wire logic [2:0]                    tx_class,
  input  wire logic [3:0]                    tx_flits,
  output logic                               tx_grant,
  output logic                               tx_on_shared,
  output logic                               tx_refused,
  // credit return from the remote side
  input  wire logic                          ret_valid,
  input  wire logic                          ret_shared,
  input  wire logic                          ret_vn,
  input  wire logic [2:0]                    ret_class,
  input  wire logic [3:0]                    ret_count,
  // flow queue and crosspoint prefetch
  input  wire logic                          fq_prefetch_spawn,
  input  wire logic [6:0]                    xpt_stage,
  // writeback occupancy
  input  wire logic [lcem_pkg::OCC_W-1:0]    wb_local_occ_vn0,
  input  wire logic [lcem_pkg::OCC_W-1:0]    wb_thru_occ_vn0,
  input  wire logic [lcem_pkg::OCC_W-1:0]    wb_local_occ_vn1,
  input  wire logic [lcem_pkg::OCC_W-1:0]    wb_thru_occ_vn1,
  input  wire logic [1:0]                    wb_wait_pull,
  // event increments to counters 0-3
  output logic      [lcem_pkg::NUM_SLOTS-1:0] evt_inc
);
  import lcem_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [NUM_SLOTS-1:0][7:0]     code_reg;
  logic [NUM_SLOTS-1:0][7:0]     umask_reg;
  logic [NUM_SLOTS-1:0]          en_reg;
  logic [DATA_W-1:0]             cfg_reg;
  logic                          cfg_load;
  logic [POOL_W-1:0]             pool_ad_reg;
  logic [POOL_W-1:0]             pool_data_reg;
  logic [1:0][NUM_CLASSES-1:0][CRED_W-1:0] rsv_reg;
  logic [POOL_W-1:0]             pool_ad_next;
  logic [POOL_W-1:0]             pool_data_next;
  logic [1:0][NUM_CLASSES-1:0]   rsv_empty;
  logic [1:0][NUM_CLASSES-1:0]   rsv_used_reg;
  logic                          pf_spawn_reg;
  logic [6:0]                    xpt_reg;

  assign cfg_load = reg_wr && (reg_addr == OFF_CREDIT_CFG);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      code_reg  <= '0;
      umask_reg <= '0;
      en_reg    <= '0;
    end else if (reg_wr) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        if (reg_addr == OFF_SLOT_CTL0 + 8'(4 * i)) begin
          code_reg[i]  <= reg_wdata[CTL_CODE_LSB +: 8];
          umask_reg[i] <= reg_wdata[CTL_MASK_LSB +: 8];
          en_reg[i]    <= reg_wdata[CTL_EN_BIT];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_reg <= CREDIT_CFG_RST;
    end else if (cfg_load) begin
      cfg_reg <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (reg_addr == OFF_SLOT_CTL0 + 8'(4 * i)) begin
        rd_mux[CTL_CODE_LSB +: 8] = code_reg[i];
        rd_mux[CTL_MASK_LSB +: 8] = umask_reg[i];
        rd_mux[CTL_EN_BIT]        = en_reg[i];
      end
    end
    if (reg_addr == OFF_CREDIT_CFG) begin
      rd_mux = cfg_reg;
    end
    if (reg_addr == OFF_CREDIT_STAT) begin
      rd_mux[CFG_POOL_AD_LSB +: POOL_W]   = pool_ad_reg;
      rd_mux[CFG_POOL_DATA_LSB +: POOL_W] = pool_data_reg;
    end
    if (reg_addr == OFF_EMPTY_STAT) begin
      rd_mux[0 +: NUM_CLASSES] = rsv_empty[0];
      rd_mux[8 +: NUM_CLASSES] = rsv_empty[1];
    end
  end

  // data only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // credit selection
  // ----------------------------------------------------------------
  logic                tx_ok_class;
  logic                tx_data_ring;
  logic [POOL_W-1:0]   pool_avail;
  logic                use_shared;
  logic                use_rsv;
  logic                ret_ok_class;

  assign tx_ok_class  = tx_class < 3'(NUM_CLASSES);
  assign tx_data_ring = tx_class >= CLS_FIRST_DATA;
  assign pool_avail   = tx_data_ring ? pool_data_reg : pool_ad_reg;
  assign ret_ok_class = ret_class < 3'(NUM_CLASSES);

  // R7 shared pool tried first
  assign use_shared = tx_valid && tx_ok_class && (tx_flits != 4'h0)
                      && ({2'b00, tx_flits} <= pool_avail);
  // R11 fallback only after shared failure
  assign use_rsv    = tx_valid && tx_ok_class && !use_shared
                      && (rsv_reg[tx_vn][tx_class] != '0);

  // R8 shared pool spends one per flit buffer
  function automatic logic [POOL_W-1:0] pool_step(input logic [POOL_W-1:0] cur,
                                                  input logic              take,
                                                  input logic              give);
    logic [POOL_W:0] sum;
    sum = {1'b0, cur};
    if (take) begin
      sum = sum - {3'b000, tx_flits};
    end
    if (give) begin
      sum = sum + {3'b000, ret_count};
    end
    // saturate so a surplus return cannot wrap the pool
    if (sum[POOL_W]) begin
      sum = {1'b0, {POOL_W{1'b1}}};
    end
    return sum[POOL_W-1:0];
  endfunction : pool_step

  // a process, not assign: it also wakes on the counts read inside the function
  always_comb begin
    pool_ad_next   = pool_step(pool_ad_reg, use_shared && !tx_data_ring,
                               ret_valid && ret_shared && (ret_class < CLS_FIRST_DATA));
    pool_data_next = pool_step(pool_data_reg, use_shared && tx_data_ring,
                               ret_valid && ret_shared && (ret_class >= CLS_FIRST_DATA));
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pool_ad_reg   <= CREDIT_CFG_RST[CFG_POOL_AD_LSB +: POOL_W];
      pool_data_reg <= CREDIT_CFG_RST[CFG_POOL_DATA_LSB +: POOL_W];
    end else if (cfg_load) begin
      pool_ad_reg   <= reg_wdata[CFG_POOL_AD_LSB +: POOL_W];
      pool_data_reg <= reg_wdata[CFG_POOL_DATA_LSB +: POOL_W];
    end else begin
      pool_ad_reg   <= pool_ad_next;
      pool_data_reg <= pool_data_next;
    end
  end

  // reserved credits: one per transfer whatever its flit count
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rsv_reg <= {2 * NUM_CLASSES{CREDIT_CFG_RST[CFG_RSV_LSB +: CRED_W]}};
    end else if (cfg_load) begin
      rsv_reg <= {2 * NUM_CLASSES{reg_wdata[CFG_RSV_LSB +: CRED_W]}};
    end else begin
      for (int v = 0; v < 2; v++) begin
        for (int c = 0; c < NUM_CLASSES; c++) begin
          logic take;
          logic give;
          take = use_rsv && (tx_vn == 1'(v)) && (tx_class == 3'(c));
          give = ret_valid && !ret_shared && ret_ok_class
                 && (ret_vn == 1'(v)) && (ret_class == 3'(c))
                 && (rsv_reg[v][c] != {CRED_W{1'b1}});
          // R8 one reserved credit per transfer
          if (take && !give) begin
            rsv_reg[v][c] <= rsv_reg[v][c] - 4'h1;
          end else if (give && !take) begin
            rsv_reg[v][c] <= rsv_reg[v][c] + 4'h1;
          end
        end
      end
    end
  end

  always_comb begin
    for (int v = 0; v < 2; v++) begin
      for (int c = 0; c < NUM_CLASSES; c++) begin
        rsv_empty[v][c] = (rsv_reg[v][c] == '0);
      end
    end
  end

  // transfer answer and reserved use pulses
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_grant     <= 1'b0;
      tx_on_shared <= 1'b0;
      tx_refused   <= 1'b0;
      rsv_used_reg <= '0;
    end else begin
      tx_grant     <= use_shared || use_rsv;
      tx_on_shared <= use_shared;
      tx_refused   <= tx_valid && !use_shared && !use_rsv;
      for (int v = 0; v < 2; v++) begin
        for (int c = 0; c < NUM_CLASSES; c++) begin
          // R6 zero use counted
          // R11 one use counted
          rsv_used_reg[v][c] <= use_rsv && (tx_vn == 1'(v)) && (tx_class == 3'(c));
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // condition vectors
  // ----------------------------------------------------------------
  logic [7:0] v_ad_empty;
  logic [7:0] v_data_empty;
  logic [7:0] v_vn0_used;
  logic [7:0] v_vn1_used;
  logic [7:0] v_vn0_none;
  logic [7:0] v_vn1_none;
  logic [7:0] v_xpt;
  logic [7:0] v_wb_pend;
  logic [7:0] v_cmp_any;
  logic [7:0] v_cmp_nz;
  logic [1:0] loc_nz;
  logic [1:0] thru_nz;
  logic [1:0] gt;
  logic [1:0] eq;
  logic [1:0] lt;

  // R2 address ring sources
  assign v_ad_empty   = {1'b0, rsv_empty[1][CLS_RSP_AD], rsv_empty[1][CLS_SNP], rsv_empty[1][CLS_REQ],
                         rsv_empty[0][CLS_RSP_AD], rsv_empty[0][CLS_SNP], rsv_empty[0][CLS_REQ],
                         pool_ad_reg == '0};
  // R4 data ring sources
  assign v_data_empty = {1'b0, rsv_empty[1][CLS_WB], rsv_empty[1][CLS_NONCOH], rsv_empty[1][CLS_RSP_DATA],
                         rsv_empty[0][CLS_WB], rsv_empty[0][CLS_NONCOH], rsv_empty[0][CLS_RSP_DATA],
                         pool_data_reg == '0};
  // R9 class order of credit masks
  assign v_vn0_used = {2'b00, rsv_used_reg[0][CLS_NONCOH], rsv_used_reg[0][CLS_WB],
                       rsv_used_reg[0][CLS_RSP_DATA], rsv_used_reg[0][2:0]};
  assign v_vn1_used = {2'b00, rsv_used_reg[1][CLS_NONCOH], rsv_used_reg[1][CLS_WB],
                       rsv_used_reg[1][CLS_RSP_DATA], rsv_used_reg[1][2:0]};
  assign v_vn0_none = {2'b00, rsv_empty[0][CLS_NONCOH], rsv_empty[0][CLS_WB],
                       rsv_empty[0][CLS_RSP_DATA], rsv_empty[0][2:0]};
  assign v_vn1_none = {2'b00, rsv_empty[1][CLS_NONCOH], rsv_empty[1][CLS_WB],
                       rsv_empty[1][CLS_RSP_DATA], rsv_empty[1][2:0]};

  // stage pulses registered so events align with credit events
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      xpt_reg      <= '0;
      pf_spawn_reg <= 1'b0;
    end else begin
      // R16 drop reasons kept on separate bits
      xpt_reg      <= xpt_stage;
      // R5 spawn pulse
      pf_spawn_reg <= fq_prefetch_spawn;
    end
  end

  // R15 stage bits 0-6
  assign v_xpt = {1'b0, xpt_reg};

  // R13 occupancy compare per network
  assign loc_nz  = {wb_local_occ_vn1 != '0, wb_local_occ_vn0 != '0};
  assign thru_nz = {wb_thru_occ_vn1 != '0, wb_thru_occ_vn0 != '0};
  assign gt      = {wb_thru_occ_vn1 > wb_local_occ_vn1, wb_thru_occ_vn0 > wb_local_occ_vn0};
  assign eq      = {wb_thru_occ_vn1 == wb_local_occ_vn1, wb_thru_occ_vn0 == wb_local_occ_vn0};
  assign lt      = {wb_thru_occ_vn1 < wb_local_occ_vn1, wb_thru_occ_vn0 < wb_local_occ_vn0};
  assign v_cmp_any = {2'b00, lt[1], eq[1], gt[1], lt[0], eq[0], gt[0]};
  assign v_cmp_nz  = v_cmp_any & {2'b00, {3{loc_nz[1] & thru_nz[1]}}, {3{loc_nz[0] & thru_nz[0]}}};

  // R14 pending writebacks per network
  assign v_wb_pend = {wb_wait_pull[1], loc_nz[1] & thru_nz[1], thru_nz[1], loc_nz[1],
                      wb_wait_pull[0], loc_nz[0] & thru_nz[0], thru_nz[0], loc_nz[0]};

  // ----------------------------------------------------------------
  // counter slots
  // ----------------------------------------------------------------
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    lcem_event_sel u_sel (
      .clk          (clk),
      .reset_n      (reset_n),
      .en           (en_reg[s]),
      .code         (code_reg[s]),
      .umask        (umask_reg[s]),
      .v_ad_empty   (v_ad_empty),
      .v_data_empty (v_data_empty),
      .v_pf_spawn   (pf_spawn_reg),
      .v_vn0_used   (v_vn0_used),
      .v_vn1_used   (v_vn1_used),
      .v_vn0_none   (v_vn0_none),
      .v_vn1_none   (v_vn1_none),
      .v_xpt        (v_xpt),
      .v_wb_pend    (v_wb_pend),
      .v_cmp_any    (v_cmp_any),
      .v_cmp_nz     (v_cmp_nz),
      .inc          (evt_inc[s])
    );
  end
endmodule : lcem_monitor

// *** tb/lcem_chk.sv ***
`timescale 1ns/1ps
module lcem_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // transfer
  input wire logic        tx_valid,
  input wire logic [2:0]  tx_class,
  input wire logic        tx_grant,
  input wire logic        tx_on_shared,
  input wire logic        tx_refused,
  // prefetch and events
  input wire logic        fq_prefetch_spawn,
  input wire logic [6:0]  xpt_stage,
  input wire logic [3:0]  evt_inc
);
  import lcem_pkg::*;
  logic [31:0] ctl0_reg;
  logic [3:0]  on_reg;
  logic        spawn0;
  logic        xpt0;
  logic        xhit;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----
  // shadow of slot control writes
  // ----
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctl0_reg <= '0;
      on_reg   <= '0;
    end else if (reg_wr && reg_addr[7:4] == 4'h0 && reg_addr[1:0] == 2'h0) begin
      on_reg[reg_addr[3:2]] <= reg_wdata[CTL_EN_BIT];
      if (reg_addr == OFF_SLOT_CTL0) begin
        ctl0_reg <= reg_wdata;
      end
    end
  end
  assign spawn0 = ctl0_reg[CTL_EN_BIT] && ctl0_reg[7:0] == EV_PF_SPAWN;
  assign xpt0   = ctl0_reg[CTL_EN_BIT] && ctl0_reg[7:0] == EV_XPT_PF;
  assign xhit   = |(xpt_stage & ctl0_reg[14:8]);
  // two extra cycles of margin: enable reaches the increment one stage late
  a_slots_off_quiet: assert property ((on_reg == 4'h0) [*4] |-> evt_inc == 4'h0)
    else $error("increment from a disabled slot");
  a_spawn_counted: assert property ((spawn0 && fq_prefetch_spawn) ##1 spawn0 [*2] |-> evt_inc[0])
    else $error("spawn pulse not counted");
  a_spawn_no_extra: assert property ((spawn0 && !fq_prefetch_spawn) ##1 spawn0 [*2] |-> !evt_inc[0])
    else $error("spawn counted without pulse");
  a_xpt_stage_hit: assert property ((xpt0 && xhit) ##1 xpt0 [*2] |-> evt_inc[0])
    else $error("selected prefetch stage not counted");
  a_xpt_stage_miss: assert property ((xpt0 && !xhit) ##1 xpt0 [*2] |-> !evt_inc[0])
    else $error("unselected prefetch stage counted");
  a_bad_class_refused: assert property (tx_valid && tx_class >= 3'h6 |=> tx_refused && !tx_grant)
    else $error("illegal class not refused");
  a_one_answer: assert property (tx_valid |=> tx_grant != tx_refused)
    else $error("transfer without exactly one answer");
  a_shared_is_grant: assert property (tx_on_shared |-> tx_grant && !tx_refused)
    else $error("shared flag without grant");
  a_idle_no_answer: assert property (!tx_valid |=> !tx_grant && !tx_refused && !tx_on_shared)
    else $error("answer without request");
endmodule : lcem_chk

bind lcem_monitor lcem_chk lcem_chk_i (
  .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .tx_valid, .tx_class, .tx_grant,
  .tx_on_shared, .tx_refused, .fq_prefetch_spawn, .xpt_stage, .evt_inc
);

// *** tb/lcem_ctr_model.sv ***
`timescale 1ns/1ps
module lcem_ctr_model (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // increments from the monitor
  input wire logic [3:0]  evt_inc,
  // running totals per counter
  output logic     [15:0] count [4]
);
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!reset_n) count[i] <= '0;
      else count[i] <= count[i] + 16'(evt_inc[i]);
    end
  end
endmodule : lcem_ctr_model

// *** tb/lcem_monitor_tb.sv ***
`timescale 1ns/1ps
module lcem_monitor_tb;
  import lcem_pkg::*;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic [7:0]        reg_addr = '0;
  logic [31:0]       reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [31:0]       reg_rdata;
  logic              tx_valid = 1'b0;
  logic              tx_vn = 1'b0;
  logic [2:0]        tx_class = '0;
  logic [3:0]        tx_flits = '0;
  logic              tx_grant;
  logic              tx_on_shared;
  logic              tx_refused;
  logic              ret_valid = 1'b0;
  logic              ret_shared = 1'b0;
  logic              ret_vn = 1'b0;
  logic [2:0]        ret_class = '0;
  logic [3:0]        ret_count = '0;
  logic              fq_prefetch_spawn = 1'b0;
  logic [6:0]        xpt_stage = '0;
  logic [OCC_W-1:0]  wb_local_occ_vn0 = '0;
  logic [OCC_W-1:0]  wb_thru_occ_vn0 = '0;
  logic [OCC_W-1:0]  wb_local_occ_vn1 = '0;
  logic [OCC_W-1:0]  wb_thru_occ_vn1 = '0;
  logic [1:0]        wb_wait_pull = '0;
  logic [3:0]        evt_inc;
  logic [15:0]       count [4];
  int                miscompares = 0;
  int                check_count = 0;

  always #2 clk = ~clk;

  lcem_monitor lcem_monitor_i (
    .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tx_valid, .tx_vn, .tx_class, .tx_flits, .tx_grant, .tx_on_shared, .tx_refused,
    .ret_valid, .ret_shared, .ret_vn, .ret_class, .ret_count, .fq_prefetch_spawn, .xpt_stage,
    .wb_local_occ_vn0, .wb_thru_occ_vn0, .wb_local_occ_vn1, .wb_thru_occ_vn1, .wb_wait_pull, .evt_inc
  );
  lcem_ctr_model lcem_ctr_model_i (.clk, .reset_n, .evt_inc, .count);

  // ----
  // bus and compare tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp, "read data");
  endtask : rd
  task automatic slot(input int n, input logic [7:0] code, input logic [7:0] um);
    wr(8'(4 * n), {9'h0, 1'b1, 6'h0, um, code});
  endtask : slot
  task automatic send(input logic vn, input logic [2:0] cls, input logic [3:0] fl, input logic [2:0] exp);
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_vn    <= vn;
    tx_class <= cls;
    tx_flits <= fl;
    @(posedge clk);
    tx_valid <= 1'b0;
    @(negedge clk);
    chk({29'h0, tx_grant, tx_on_shared, tx_refused}, {29'h0, exp}, "transfer answer");
  endtask : send
  // level event on slot 0: eight steady cycles give eight counts or none
  task automatic lvl(input logic [7:0] code, input logic [7:0] um, input logic exp);
    logic [15:0] c;
    slot(0, code, um);
    repeat (3) @(posedge clk);
    @(negedge clk);
    c = count[0];
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk(32'(count[0] - c), {28'h0, exp, 3'h0}, "level count");
  endtask : lvl
  task automatic pulse(input logic [6:0] st);
    @(posedge clk);
    xpt_stage <= st;
    @(posedge clk);
    xpt_stage <= '0;
  endtask : pulse

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    rd(OFF_CREDIT_CFG, CREDIT_CFG_RST);
    rd(OFF_CREDIT_STAT, 32'h0000_2020);
    rd(OFF_EMPTY_STAT, 32'h0);
    rd(8'h40, 32'h0);
  endtask : t_reset
  task automatic t_credits();
    logic [15:0] c1;
    logic [15:0] c2;
    logic [15:0] c3;
    send(1'b0, CLS_REQ, 4'h2, 3'b110);
    rd(OFF_CREDIT_STAT, 32'h0000_201e);
    wr(OFF_CREDIT_CFG, 32'h0001_0203);
    slot(1, EV_VN0_USED, 8'h11);
    slot(2, EV_VN1_USED, 8'h02);
    slot(3, EV_VN1_USED, 8'h02);
    rd(8'h0c, 32'h0040_025c);
    c1 = count[1];
    c2 = count[2];
    c3 = count[3];
    send(1'b0, CLS_REQ, 4'h4, 3'b100);
    send(1'b0, CLS_REQ, 4'h4, 3'b001);
    send(1'b0, CLS_REQ, 4'h3, 3'b110);
    send(1'b1, CLS_SNP, 4'h1, 3'b100);
    send(1'b0, CLS_WB, 4'h2, 3'b110);
    send(1'b0, CLS_WB, 4'h1, 3'b100);
    send(1'b0, 3'h6, 4'h1, 3'b001);
    repeat (3) @(posedge clk);
    chk(32'(count[1] - c1), 32'h2, "vn0 used");
    chk(32'(count[2] - c2), 32'h1, "vn1 used");
    chk(32'(count[3] - c3), 32'h1, "vn1 used slot 3");
    rd(OFF_CREDIT_STAT, 32'h0);
    rd(OFF_EMPTY_STAT, 32'h0000_0211);
    lvl(EV_AD_EMPTY, 8'h01, 1'b1);
    lvl(EV_AD_EMPTY, 8'h04, 1'b0);
    lvl(EV_AD_EMPTY, 8'h22, 1'b1);
    lvl(EV_DATA_EMPTY, 8'h01, 1'b1);
    lvl(EV_DATA_EMPTY, 8'h08, 1'b1);
    lvl(EV_DATA_EMPTY, 8'h12, 1'b0);
    lvl(EV_VN0_NONE, 8'h02, 1'b0);
    lvl(EV_VN0_NONE, 8'h12, 1'b1);
    lvl(EV_VN1_NONE, 8'h02, 1'b1);
    lvl(EV_VN1_NONE, 8'h01, 1'b0);
    lvl(8'h00, 8'hff, 1'b0);
    @(posedge clk);
    ret_valid  <= 1'b1;
    ret_shared <= 1'b1;
    ret_count  <= 4'h5;
    @(posedge clk);
    ret_shared <= 1'b0;
    @(posedge clk);
    ret_valid <= 1'b0;
    rd(OFF_CREDIT_STAT, 32'h0000_0005);
    rd(OFF_EMPTY_STAT, 32'h0000_0210);
    lvl(EV_AD_EMPTY, 8'h01, 1'b0);
  endtask : t_credits
  task automatic t_prefetch();
    logic [15:0] c;
    slot(0, EV_PF_SPAWN, 8'h00);
    c = count[0];
    @(posedge clk);
    fq_prefetch_spawn <= 1'b1;
    repeat (3) @(posedge clk);
    fq_prefetch_spawn <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(count[0] - c), 32'h3, "spawn count");
    for (int i = 0; i < 7; i++) begin
      slot(0, EV_XPT_PF, 8'h01 << i);
      c = count[0];
      pulse(7'h01 << i);
      pulse(~(7'h01 << i));
      repeat (3) @(posedge clk);
      chk(32'(count[0] - c), 32'h1, "stage count");
    end
    slot(0, EV_XPT_PF, 8'h60);
    c = count[0];
    pulse(7'h20);
    pulse(7'h40);
    repeat (3) @(posedge clk);
    chk(32'(count[0] - c), 32'h2, "drop count");
  endtask : t_prefetch
  task automatic t_wb();
    wb_thru_occ_vn0  <= 8'h05;
    wb_local_occ_vn0 <= 8'h03;
    wb_thru_occ_vn1  <= 8'h02;
    wb_local_occ_vn1 <= 8'h02;
    lvl(EV_WB_CMP, 8'h01, 1'b1);
    lvl(EV_WB_CMP, 8'h06, 1'b0);
    lvl(EV_WB_CMP, 8'h10, 1'b1);
    lvl(EV_WB_CMP, 8'h81, 1'b1);
    @(posedge clk);
    wb_local_occ_vn0 <= 8'h00;
    lvl(EV_WB_CMP, 8'h81, 1'b0);
    lvl(EV_WB_PEND, 8'h05, 1'b0);
    lvl(EV_WB_PEND, 8'h02, 1'b1);
    @(posedge clk);
    wb_wait_pull <= 2'b01;
    lvl(EV_WB_PEND, 8'h08, 1'b1);
    lvl(EV_WB_PEND, 8'h40, 1'b1);
  endtask : t_wb

  task automatic stop_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_credits();
    t_prefetch();
    t_wb();
    stop_test();
  end
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
endmodule : lcem_monitor_tb
